// ===== hw/sft_channel.sv
`timescale 1ns/1ns
module sft_channel (
  // Clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST_N,
  // Link to the sequencer
  sft_link_if.chan                       LINK,
  // Tape word stream
  input  wire logic                      TAPE_VALID,
  input  wire logic [sft_pkg::DW_W-1:0]  TAPE_DATA,
  input  wire logic                      TAPE_GAP,
  output logic                           TAPE_READY,
  // Operator buttons and tape repositioning
  input  wire logic                      BACKSPACE_BTN,
  input  wire logic                      LOAD_BTN,
  output logic                           TAPE_BACKSPACE
);
  import sft_pkg::*;

  logic                 fill_buf_reg, fill_buf_next;
  logic [IDX_W-1:0]     idx_reg, idx_next;
  logic                 ready_reg, ready_next;
  logic                 wr_en_reg;
  logic [ADDR_W-1:0]    wr_addr_reg, wr_addr_next;
  logic [DW_W-1:0]      wr_data_reg;
  logic                 sw_reg, sw_buf_reg, gap_reg, reload_reg;
  logic [1:0]           bksp_reg, bksp_next;

  // Word acceptance and record position
  wire                  accept     = TAPE_VALID & ready_reg;
  wire                  last_word  = accept & (idx_reg == NUM_WORD);
  wire                  fire       = LOAD_BTN & (bksp_reg == 2'h2);
  wire [ADDR_W-1:0]     fill_base  = fill_buf_reg ? BUF1_BASE : BUF0_BASE;

  // Fill sequentially, alternating buffers with no other addressing [R3] [R2] [R1]
  assign wr_addr_next  = fill_base + {4'h0, idx_reg, 3'h0};
  assign idx_next      = (fire | last_word) ? 5'h00 : (accept ? idx_reg + 5'h01 : idx_reg);
  assign fill_buf_next = fire ? 1'b0 : (last_word ? ~fill_buf_reg : fill_buf_reg);
  // Never refill a buffer the sequencer still owns; one idle cycle after each record [R3]
  assign ready_next    = ~last_word & ~fire & ~LINK.buf_full[fill_buf_next];
  // Two backspaces then load rewinds the record; a load after fewer restarts the count, further backspaces hold it at two [R10]
  assign bksp_next     = LOAD_BTN ? 2'h0 :
                         (BACKSPACE_BTN && bksp_reg != 2'h2) ? bksp_reg + 2'h1 : bksp_reg;

  // Fill position and handshake
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fill_buf_reg <= 1'b0;
      idx_reg      <= 5'h00;
      ready_reg    <= 1'b0;
      bksp_reg     <= 2'h0;
    end else begin
      fill_buf_reg <= fill_buf_next;
      idx_reg      <= idx_next;
      ready_reg    <= ready_next;
      bksp_reg     <= bksp_next;
    end
  end

  // Registered link drive; switch pulse lands with the last write [R3]
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 12'h000;
      wr_data_reg <= 64'h0000_0000_0000_0000;
      sw_reg      <= 1'b0;
      sw_buf_reg  <= 1'b0;
      gap_reg     <= 1'b0;
      reload_reg  <= 1'b0;
    end else begin
      wr_en_reg   <= accept;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= TAPE_DATA;
      sw_reg      <= last_word;
      sw_buf_reg  <= fill_buf_reg;
      gap_reg     <= TAPE_GAP;
      reload_reg  <= fire; // [R10]
    end
  end

  // Outputs
  assign LINK.wr_en               = wr_en_reg;
  assign LINK.wr_addr             = wr_addr_reg;
  assign LINK.wr_data             = wr_data_reg;
  assign LINK.buffer_switch_pulse = sw_reg;
  assign LINK.switch_buf          = sw_buf_reg;
  assign LINK.record_gap          = gap_reg;
  assign LINK.reload              = reload_reg;
  assign TAPE_READY               = ready_reg;
  assign TAPE_BACKSPACE           = reload_reg;
endmodule

// ===== hw/sft_link_if.sv
`timescale 1ns/1ns
interface sft_link_if;
  import sft_pkg::*;

  // Buffer fill path, channel to sequencer
  logic                 wr_en;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DW_W-1:0]      wr_data;
  // Events from the channel
  logic                 buffer_switch_pulse;
  logic                 switch_buf;
  logic                 record_gap;
  logic                 reload;
  // Buffer occupancy seen by the channel
  logic [1:0]           buf_full;

  modport dev (
    input  wr_en, wr_addr, wr_data, buffer_switch_pulse, switch_buf, record_gap, reload,
    output buf_full
  );
  modport chan (
    output wr_en, wr_addr, wr_data, buffer_switch_pulse, switch_buf, record_gap, reload,
    input  buf_full
  );
endinterface

// ===== hw/sft_pkg.sv
package sft_pkg;
  // Word and address widths
  localparam int DW_W   = 64;
  localparam int HALF_W = 32;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 5;
  localparam int CNT_W  = 4;

  // Test record layout
  localparam int                TEST_WORDS   = 17;
  localparam logic [IDX_W-1:0]  PATTERN_WORD = 5'h00;
  localparam logic [IDX_W-1:0]  CTL_WORD     = 5'h01;
  localparam logic [IDX_W-1:0]  FIRST_BODY   = 5'h02;
  localparam logic [IDX_W-1:0]  LAST_SCAN    = 5'h0F;
  localparam logic [IDX_W-1:0]  REPEAT_START = 5'h0F;
  localparam logic [IDX_W-1:0]  NUM_WORD     = 5'h10;
  localparam logic [CNT_W-1:0]  SCAN_LAST_CNT = 4'hE;

  // Buffer storage locations, one doubleword is eight bytes
  localparam logic [ADDR_W-1:0] BUF0_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] BUF1_BASE = 12'h200;
  localparam int                DW_SHIFT  = 3;

  // Control word fields
  localparam int CTL_EXPECT_BIT = 0;
  localparam int CTL_ZERO_CYC   = 1;
  localparam int CTL_CYC_LSB    = 8;
  localparam int CTL_CYC_W      = 4;

  // Reset values
  localparam logic [HALF_W-1:0] HOLD_RST = 32'h0000_0000;
endpackage

// ===== hw/sft_result_check.sv
`timescale 1ns/1ns
module sft_result_check #(
  parameter int W = 32
) (
  // Scanned word and selecting mask
  input  wire logic [W-1:0] word_in,
  input  wire logic [W-1:0] mask_in,
  // High when the inverted OR is all zero
  output logic              zero
);
  // Negative OR into the check path; zero only if every bit is covered
  assign zero = &(word_in | mask_in);
endmodule

// ===== hw/sft_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// [R1] A test is doublewords zero to sixteen
// [R2] Two buffers, at 100h and 200h
// [R3] Channel fills one buffer, device runs other
// [R4] Words 0 and 2-15 are scanned in
// [R5] Word 1: mask left, control word right
// [R6] Word 16 read only on fail or search
// [R7] Pass sets trigger, repeat starts at word 15
// [R8] Fail sets trigger, fetch word 16 after switch
// [R9] Mismatch stops; failing number in S(0-15)
// [R10] Two backspaces then load rewind the record
// [R11] Search compares new number with stored alternate
// [R12] Zero search result resumes normal testing
// [R13] Zero-cycle mode scans in without clocking
// [R14] Triggers hold without clock; zeros reset
// [R15] One-cycle mode clocks the specified cycles
// [R16] Scan-out ORed with mask, then inverted
// [R17] Pass or fail from result and expected bit
// [R18] Repeat test until switch or gap seen
// [R19] Clear pass and fail at test start
// [R20] Both triggers set means intermittent failure
module sft_sequencer (
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST_N,
  // Link to the channel
  sft_link_if.dev                          LINK,
  // Scan-in to the element triggers
  output logic                             SCAN_IN_VALID,
  output logic [sft_pkg::IDX_W-1:0]        SCAN_IN_WORD,
  output logic [sft_pkg::DW_W-1:0]         SCAN_IN_DATA,
  // Element clock advance and scan-out
  output logic                             ELEM_CLK_EN,
  output logic                             SCAN_OUT_STROBE,
  input  wire logic [sft_pkg::HALF_W-1:0]  SCAN_OUT_WORD,
  // Status and display
  output logic                             PASS_TRIG,
  output logic                             FAIL_TRIG,
  output logic                             INTERMITTENT,
  output logic                             TEST_STOPPED,
  output logic                             SEARCHING,
  output logic [sft_pkg::HALF_W-1:0]       HOLD_S,
  output logic [sft_pkg::HALF_W-1:0]       HOLD_T
);
  import sft_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOAD_CTL, ST_SCAN, ST_ADV, ST_SO, ST_SO_CAP, ST_CHECK,
    ST_WAIT_SWITCH, ST_FETCH_NUM, ST_STOP, ST_SRCH_LOAD, ST_SRCH_CHECK
  } sft_state_t;

  // Two test buffers of seventeen doublewords each
  logic [DW_W-1:0]       mem [0:1][0:TEST_WORDS-1];

  sft_state_t            state_reg, state_next;
  logic                  exec_reg, exec_next;
  logic [1:0]            full_reg, full_next;
  logic                  gap_reg, gap_next;
  logic                  search_reg, search_next;
  logic                  pass_reg, pass_next;
  logic                  fail_reg, fail_next;
  logic                  stop_reg, stop_next;
  logic [IDX_W-1:0]      addr_reg, addr_next;
  logic [CNT_W-1:0]      cnt_reg, cnt_next;
  logic [CTL_CYC_W-1:0]  cyc_reg, cyc_next;
  logic [HALF_W-1:0]     mask_reg, mask_next;
  logic [HALF_W-1:0]     ctl_reg, ctl_next;
  logic [HALF_W-1:0]     so_reg, so_next;
  logic [HALF_W-1:0]     hold_s_reg, hold_s_next;
  logic [HALF_W-1:0]     hold_t_reg, hold_t_next;
  logic                  release_buf;
  logic                  scan_valid_reg, clk_en_reg, strobe_reg;
  logic [IDX_W-1:0]      scan_idx_reg;
  logic [DW_W-1:0]       scan_data_reg;
  logic                  test_zero, srch_zero;
  logic                  intermittent_reg;

  // Write decode: doubleword aligned and inside one of the two buffers [R2] [R1]
  wire [IDX_W-1:0]       wr_idx   = LINK.wr_addr[DW_SHIFT+IDX_W-1:DW_SHIFT];
  wire                   wr_in0   = LINK.wr_addr[ADDR_W-1:8] == BUF0_BASE[ADDR_W-1:8];
  wire                   wr_in1   = LINK.wr_addr[ADDR_W-1:8] == BUF1_BASE[ADDR_W-1:8];
  wire                   wr_align = (LINK.wr_addr[DW_SHIFT-1:0] == 3'h0) && (wr_idx <= NUM_WORD);
  wire                   wr_hit   = LINK.wr_en & wr_align & (wr_in0 | wr_in1);

  // Read selection: control word, scan word or the number word [R5] [R4] [R6]
  wire [IDX_W-1:0]       rd_idx   = (state_reg == ST_LOAD_CTL) ? CTL_WORD :
                                    (state_reg == ST_SCAN) ? addr_reg : NUM_WORD;
  wire [DW_W-1:0]        rd_word  = mem[exec_reg][rd_idx];
  wire [HALF_W-1:0]      rd_left  = rd_word[DW_W-1:HALF_W];
  wire [HALF_W-1:0]      rd_right = rd_word[HALF_W-1:0];

  // Scan order skips the control word; wraps so a repeat from 15 still covers all [R4] [R7]
  wire [IDX_W-1:0]       addr_step = (addr_reg == LAST_SCAN) ? PATTERN_WORD :
                                     (addr_reg == PATTERN_WORD) ? FIRST_BODY : addr_reg + 5'h01;

  // Control word decode [R13] [R15]
  wire                   zero_cyc  = ctl_reg[CTL_ZERO_CYC];
  wire [CTL_CYC_W-1:0]   cyc_field = zero_cyc ? 4'h0 : ctl_reg[CTL_CYC_LSB+CTL_CYC_W-1:CTL_CYC_LSB];
  wire                   expected  = ctl_reg[CTL_EXPECT_BIT];
  // Zero result with expected one, or nonzero with expected zero, passes [R17]
  wire                   test_pass = (test_zero == expected);
  // Alternate buffer filled, or the record has ended [R18]
  wire                   alt_full  = full_reg[~exec_reg];
  wire                   done_rep  = alt_full | gap_reg;
  // Number word holds each number beside its complement; T halves swapped so equal gives all ones
  wire [HALF_W-1:0]      t_swap    = {hold_t_reg[HALF_W/2-1:0], hold_t_reg[HALF_W-1:HALF_W/2]};

  // Exit trigger check through the inverted OR path [R16]
  sft_result_check #(.W(HALF_W)) u_exit_check (
    .word_in (so_reg),
    .mask_in (mask_reg),
    .zero    (test_zero)
  );

  // Number comparison by the paired scan-out of S and T [R11]
  sft_result_check #(.W(HALF_W)) u_search_check (
    .word_in (hold_s_reg),
    .mask_in (t_swap),
    .zero    (srch_zero)
  );

  // Buffer storage, filled only by the channel [R3]
  always_ff @(posedge SYS_CLK) begin
    if (wr_hit) begin
      mem[wr_in1][wr_idx] <= LINK.wr_data;
    end
  end

  // Sequencer next state
  always_comb begin
    state_next  = state_reg;
    exec_next   = exec_reg;
    full_next   = full_reg;
    gap_next    = gap_reg;
    search_next = search_reg;
    pass_next   = pass_reg;
    fail_next   = fail_reg;
    stop_next   = stop_reg;
    addr_next   = addr_reg;
    cnt_next    = cnt_reg;
    cyc_next    = cyc_reg;
    mask_next   = mask_reg;
    ctl_next    = ctl_reg;
    so_next     = so_reg;
    hold_s_next = hold_s_reg;
    hold_t_next = hold_t_reg;
    release_buf = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (full_reg[exec_reg]) begin
          if (search_reg) begin
            state_next = ST_SRCH_LOAD;
          end else begin
            state_next = ST_LOAD_CTL;
            pass_next  = 1'b0; // [R19]
            fail_next  = 1'b0; // [R19]
            gap_next   = 1'b0;
            addr_next  = PATTERN_WORD;
          end
        end
      end
      ST_LOAD_CTL: begin
        mask_next  = rd_left;  // [R5]
        ctl_next   = rd_right; // [R5]
        cnt_next   = 4'h0;
        state_next = ST_SCAN;
      end
      ST_SCAN: begin
        cnt_next  = cnt_reg + 4'h1;
        addr_next = addr_step; // [R4]
        if (cnt_reg == SCAN_LAST_CNT) begin
          state_next = ST_ADV;
          cyc_next   = cyc_field; // [R13] [R15]
        end
      end
      ST_ADV: begin
        // Element clock runs only here, so triggers hold between tests [R14] [R15]
        if (cyc_reg == 4'h0) begin
          state_next = ST_SO;
        end else begin
          cyc_next = cyc_reg - 4'h1;
        end
      end
      ST_SO: begin
        state_next = ST_SO_CAP;
      end
      ST_SO_CAP: begin
        so_next    = SCAN_OUT_WORD;
        state_next = ST_CHECK;
      end
      ST_CHECK: begin
        if (test_pass) begin
          pass_next = 1'b1;         // [R7]
          addr_next = REPEAT_START; // [R7]
          cnt_next  = 4'h0;
          if (done_rep) begin
            release_buf = 1'b1; // [R18]
            state_next  = ST_IDLE;
          end else begin
            state_next = ST_SCAN; // [R18]
          end
        end else begin
          fail_next  = 1'b1; // [R8] [R9]
          state_next = ST_WAIT_SWITCH;
        end
      end
      ST_WAIT_SWITCH: begin
        // Gap also ends the wait, otherwise the last test of a record would hang
        if (done_rep) begin
          state_next = ST_FETCH_NUM; // [R8]
        end
      end
      ST_FETCH_NUM: begin
        hold_s_next = rd_left;  // [R8] [R9] [R6]
        hold_t_next = rd_right; // [R8] [R6]
        stop_next   = 1'b1;     // [R9]
        state_next  = ST_STOP;
      end
      ST_STOP: begin
        // Pass and fail both stay visible while stopped [R20]
        if (LINK.reload) begin
          stop_next   = 1'b0;
          search_next = 1'b1; // [R10] [R11]
          exec_next   = 1'b0;
          full_next   = 2'b00;
          state_next  = ST_IDLE;
        end
      end
      ST_SRCH_LOAD: begin
        hold_s_next = rd_left; // [R11] [R6]
        state_next  = ST_SRCH_CHECK;
      end
      ST_SRCH_CHECK: begin
        if (srch_zero) begin
          search_next = 1'b0; // [R12]
        end else begin
          release_buf = 1'b1;
        end
        state_next = ST_IDLE;
      end
    endcase
    // Hand the executed buffer back to the channel [R3]
    if (release_buf) begin
      full_next[exec_reg] = 1'b0;
      exec_next           = ~exec_reg;
    end
    // Events after clears: a switch or gap in the clearing cycle is kept
    if (LINK.buffer_switch_pulse) begin
      full_next[LINK.switch_buf] = 1'b1; // [R3]
    end
    if (LINK.record_gap) begin
      gap_next = 1'b1; // [R18]
    end
  end

  // Control and status registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= ST_IDLE;
      exec_reg   <= 1'b0;
      full_reg   <= 2'b00;
      gap_reg    <= 1'b0;
      search_reg <= 1'b0;
      pass_reg   <= 1'b0;
      fail_reg   <= 1'b0;
      stop_reg   <= 1'b0;
      addr_reg   <= PATTERN_WORD;
      cnt_reg    <= 4'h0;
      cyc_reg    <= 4'h0;
      intermittent_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      exec_reg   <= exec_next;
      full_reg   <= full_next;
      gap_reg    <= gap_next;
      search_reg <= search_next;
      pass_reg   <= pass_next;
      fail_reg   <= fail_next;
      stop_reg   <= stop_next;
      addr_reg   <= addr_next;
      cnt_reg    <= cnt_next;
      cyc_reg    <= cyc_next;
      intermittent_reg <= pass_next & fail_next; // [R20]
    end
  end

  // Data holding registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_reg   <= HOLD_RST;
      ctl_reg    <= HOLD_RST;
      so_reg     <= HOLD_RST;
      hold_s_reg <= HOLD_RST;
      hold_t_reg <= HOLD_RST;
    end else begin
      mask_reg   <= mask_next;
      ctl_reg    <= ctl_next;
      so_reg     <= so_next;
      hold_s_reg <= hold_s_next;
      hold_t_reg <= hold_t_next;
    end
  end

  // Element-side strobes, registered one cycle behind the state
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scan_valid_reg <= 1'b0;
      scan_idx_reg   <= PATTERN_WORD;
      scan_data_reg  <= 64'h0000_0000_0000_0000;
      clk_en_reg     <= 1'b0;
      strobe_reg     <= 1'b0;
    end else begin
      scan_valid_reg <= (state_reg == ST_SCAN); // [R4]
      scan_idx_reg   <= addr_reg;
      scan_data_reg  <= rd_word;
      clk_en_reg     <= (state_reg == ST_ADV) && (cyc_reg != 4'h0); // [R15]
      strobe_reg     <= (state_reg == ST_ADV) && (cyc_reg == 4'h0);
    end
  end

  // Outputs
  assign LINK.buf_full    = full_reg;
  assign SCAN_IN_VALID    = scan_valid_reg;
  assign SCAN_IN_WORD     = scan_idx_reg;
  assign SCAN_IN_DATA     = scan_data_reg;
  assign ELEM_CLK_EN      = clk_en_reg;
  assign SCAN_OUT_STROBE  = strobe_reg;
  assign PASS_TRIG        = pass_reg;
  assign FAIL_TRIG        = fail_reg;
  assign INTERMITTENT     = intermittent_reg; // [R20]
  assign TEST_STOPPED     = stop_reg;
  assign SEARCHING        = search_reg;
  assign HOLD_S           = hold_s_reg; // [R9]
  assign HOLD_T           = hold_t_reg;
endmodule

// ===== sim/scan_fault_test_sequencer_tb.sv
`timescale 1ns/1ns
module scan_fault_test_sequencer_tb;
  import sft_pkg::*;
  // Design inputs, valued at time zero
  logic              SYS_CLK = 1'b0;
  logic              RST_N = 1'b0;
  logic              TAPE_VALID = 1'b0;
  logic              TAPE_GAP = 1'b0;
  logic              BACKSPACE_BTN = 1'b0;
  logic              LOAD_BTN = 1'b0;
  logic [DW_W-1:0]   TAPE_DATA = '0;
  logic [HALF_W-1:0] SCAN_OUT_WORD = '0;
  // Design outputs
  logic              TAPE_READY, TAPE_BACKSPACE, SCAN_IN_VALID, ELEM_CLK_EN, SCAN_OUT_STROBE;
  logic              PASS_TRIG, FAIL_TRIG, INTERMITTENT, TEST_STOPPED, SEARCHING;
  logic [IDX_W-1:0]  SCAN_IN_WORD;
  logic [DW_W-1:0]   SCAN_IN_DATA;
  logic [HALF_W-1:0] HOLD_S, HOLD_T;
  // Bench state
  int                errors = 0;
  int                checks = 0;
  int                cyc = 0;
  int                cur = 0;
  int                prv = -1;
  int                strobes = 0;
  int                clks = 0;
  int                exp_q[$];
  logic [DW_W-1:0]   rec[6][TEST_WORDS];
  logic [HALF_W-1:0] so_val[6];
  int                pbit[6];
  logic [3:0]        ncyc[6];
  logic [15:0]       tns[7];
  logic [IDX_W-1:0]  last_w = '0;
  logic [IDX_W-1:0]  nx;
  logic              strb_seen = 1'b0;
  logic              pass_l = 1'b0;
  logic              fail_l = 1'b0;

  sft_link_if link();
  sft_channel sft_channel_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LINK(link), .TAPE_VALID(TAPE_VALID),
    .TAPE_DATA(TAPE_DATA), .TAPE_GAP(TAPE_GAP), .TAPE_READY(TAPE_READY), .BACKSPACE_BTN(BACKSPACE_BTN),
    .LOAD_BTN(LOAD_BTN), .TAPE_BACKSPACE(TAPE_BACKSPACE));
  sft_sequencer sft_sequencer_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LINK(link),
    .SCAN_IN_VALID(SCAN_IN_VALID), .SCAN_IN_WORD(SCAN_IN_WORD), .SCAN_IN_DATA(SCAN_IN_DATA),
    .ELEM_CLK_EN(ELEM_CLK_EN), .SCAN_OUT_STROBE(SCAN_OUT_STROBE), .SCAN_OUT_WORD(SCAN_OUT_WORD),
    .PASS_TRIG(PASS_TRIG), .FAIL_TRIG(FAIL_TRIG), .INTERMITTENT(INTERMITTENT),
    .TEST_STOPPED(TEST_STOPPED), .SEARCHING(SEARCHING), .HOLD_S(HOLD_S), .HOLD_T(HOLD_T));
  sft_props sft_props_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .wr_en(link.wr_en), .wr_addr(link.wr_addr),
    .buffer_switch_pulse(link.buffer_switch_pulse), .switch_buf(link.switch_buf),
    .reload(link.reload), .buf_full(link.buf_full));

  // Clock and a hang limit well above the expected run
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    forever @(posedge SYS_CLK) if (++cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One record; the exit bit equals the expected bit so the test passes unless k is 4
  task automatic build(int k);
    int p;
    bit e, z;
    logic [3:0] cf;
    p = $urandom_range(31);
    e = k inside {1, 3, 4};
    z = ~k[0];
    cf = 4'($urandom_range(1, 15));
    ncyc[k] = z ? 4'h0 : cf;
    pbit[k] = p;
    for (int i = 0; i < TEST_WORDS; i++)
      rec[k][i] = {$urandom, $urandom};
    rec[k][1] = {~(32'h1 << p), 20'h0, cf, 6'h0, z, e};
    rec[k][16] = {tns[k], ~tns[k], tns[k+1], ~tns[k+1]};
    so_val[k] = ($urandom & ~(32'h1 << p)) | (32'(e ^ (k == 4)) << p);
  endtask

  // Tape words, valid held until the channel takes each one
  task automatic send(int k);
    for (int i = 0; i < TEST_WORDS; i++) begin
      TAPE_VALID = 1'b1;
      TAPE_DATA = rec[k][i];
      do @(posedge SYS_CLK); while (TAPE_READY !== 1'b1);
      #1;
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge SYS_CLK);
    #1 s = 1'b1;
    @(posedge SYS_CLK);
    #1 s = 1'b0;
  endtask

  // Scan traffic monitor; takes the next expected test at each test start
  always @(posedge SYS_CLK) if (RST_N) begin
    if (SCAN_IN_VALID === 1'b1) begin
      nx = strb_seen ? 5'h0F : last_w == 5'h00 ? 5'h02 : last_w == 5'h0F ? 5'h00 : last_w + 5'h01;
      if (SCAN_IN_WORD === 5'h00 && (strb_seen || last_w !== 5'h0F)) begin
        if (prv >= 0 && prv != 2)
          cmp("verdict", 64'h2, 64'({pass_l, fail_l}));
        cmp("cleared", 64'h0, 64'({PASS_TRIG, FAIL_TRIG}));
        cur = exp_q.pop_front();
        prv = cur;
        pass_l = 1'b0;
        fail_l = 1'b0;
        strobes = 0;
        SCAN_OUT_WORD <= #1 so_val[cur];
      end else
        cmp("word order", 64'(nx), 64'(SCAN_IN_WORD));
      cmp("scan data", rec[cur][SCAN_IN_WORD], SCAN_IN_DATA);
      cmp("scan in search", 64'h0, 64'(SEARCHING));
      last_w = SCAN_IN_WORD;
      strb_seen = 1'b0;
      clks = 0;
    end
    if (ELEM_CLK_EN === 1'b1)
      clks++;
    if (SCAN_OUT_STROBE === 1'b1) begin
      cmp("clock count", 64'(ncyc[cur]), 64'(clks));
      strb_seen = 1'b1;
      strobes++;
      // Exit value goes wrong on the second run of test 2, after one passing run
      if (cur == 2 && strobes == 2)
        SCAN_OUT_WORD <= #1 so_val[2] ^ (32'h1 << pbit[2]);
    end
    pass_l = pass_l | (PASS_TRIG === 1'b1);
    fail_l = fail_l | (FAIL_TRIG === 1'b1);
  end

  // Main sequence
  initial begin
    void'($urandom(39));
    for (int k = 0; k < 7; k++)
      tns[k] = {8'($urandom), 8'(k)};
    for (int k = 0; k < 6; k++)
      build(k);
    repeat (10) @(posedge SYS_CLK);
    #1 RST_N = 1'b1;
    // Two passing tests, then one that fails after passing
    exp_q = {0, 1, 2};
    send(0);
    send(1);
    send(2);
    TAPE_VALID = 1'b0;
    while (FAIL_TRIG !== 1'b1) @(posedge SYS_CLK);
    #1;
    send(3);
    TAPE_VALID = 1'b0;
    while (TEST_STOPPED !== 1'b1) @(posedge SYS_CLK);
    #1;
    cmp("failing number", 64'(tns[2]), 64'(HOLD_S[31:16]));
    cmp("hold T", 64'(rec[2][16][31:0]), 64'(HOLD_T));
    cmp("intermittent", 64'h7, 64'({PASS_TRIG, FAIL_TRIG, INTERMITTENT}));
    // Skip the failing test and rerun the record from its start
    pulse(BACKSPACE_BTN);
    pulse(BACKSPACE_BTN);
    pulse(LOAD_BTN);
    while (TAPE_BACKSPACE !== 1'b1) @(posedge SYS_CLK);
    // Sequencer takes the reload one cycle after the channel drives it
    @(posedge SYS_CLK);
    #1;
    cmp("search state", 64'h2, 64'({SEARCHING, TEST_STOPPED}));
    exp_q.push_back(3);
    exp_q.push_back(4);
    // Rerun up to the failing test; a record gap then ends its wait
    for (int k = 0; k < 5; k++)
      send(k);
    TAPE_VALID = 1'b0;
    while (exp_q.size() != 0 || FAIL_TRIG !== 1'b1) @(posedge SYS_CLK);
    pulse(TAPE_GAP);
    while (TEST_STOPPED !== 1'b1) @(posedge SYS_CLK);
    #1;
    cmp("hold S", 64'(rec[4][16][63:32]), 64'(HOLD_S));
    cmp("hold T", 64'(rec[4][16][31:0]), 64'(HOLD_T));
    cmp("plain fail", 64'h2, 64'({PASS_TRIG, FAIL_TRIG, INTERMITTENT}));
    cmp("tests run", 64'h0, 64'(exp_q.size()));
    tally_and_finish();
  end
endmodule

// ===== sim/sft_props.sv
`timescale 1ns/1ns
module sft_props
  import sft_pkg::*;
(
  // Clock and reset
  input wire logic              SYS_CLK,
  input wire logic              RST_N,
  // Link signals watched
  input wire logic              wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic              buffer_switch_pulse,
  input wire logic              switch_buf,
  input wire logic              reload,
  input wire logic [1:0]        buf_full
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  logic [ADDR_W-1:0] nxt_reg;
  // Fill address expected next; a rewind restarts at the first buffer
  wire               last_w   = wr_addr[7:0] == 8'h80;
  wire [ADDR_W-1:0]  nxt_next = reload ? BUF0_BASE : !wr_en ? nxt_reg :
                                !last_w ? wr_addr + 12'h008 : wr_addr[9] ? BUF0_BASE : BUF1_BASE;
  always_ff @(posedge SYS_CLK or negedge RST_N)
    if (!RST_N)
      nxt_reg <= BUF0_BASE;
    else
      nxt_reg <= nxt_next;

  // Last word of a record and the rewind that follows a reload
  sequence s_fill_done;
    buffer_switch_pulse && wr_en && last_w;
  endsequence
  sequence s_rewound;
    ##1 (buf_full == 2'b00) && !reload;
  endsequence

  chk_addr_range: assert property (wr_en |-> wr_addr[2:0] == 3'h0 && wr_addr[7:0] <= 8'h80 &&
    (wr_addr[11:8] == 4'h1 || wr_addr[11:8] == 4'h2)) else $error("fill outside buffers");
  chk_fill_order: assert property (wr_en |-> wr_addr == nxt_reg)
    else $error("fill order broken");
  chk_switch_last: assert property (buffer_switch_pulse |-> s_fill_done)
    else $error("switch pulse not on word sixteen");
  chk_last_switch: assert property (wr_en && last_w |-> buffer_switch_pulse)
    else $error("word sixteen without switch pulse");
  chk_switch_id: assert property (buffer_switch_pulse |-> switch_buf == wr_addr[9])
    else $error("switch names wrong buffer");
  chk_full_after: assert property (s_fill_done |=> buf_full[$past(switch_buf)])
    else $error("filled buffer not handed over");
  chk_no_overfill: assert property (wr_en |-> !buf_full[wr_addr[9]])
    else $error("write into executing buffer");
  chk_rewind_clear: assert property (reload |-> s_rewound)
    else $error("reload did not rewind");
endmodule
